// file: src/pin_select_map.svh
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define SERIAL_IN_PIN_CONTROL_ADDR      8'h36
`define SPI_OUT_PIN_CONTROL_ADDR        8'h37
`define SPI_CLOCK_PIN_CONTROL_ADDR      8'h38
`define GENERAL_INPUTS_PIN_CONTROL_ADDR 8'h39

// ==========================================================================
// Reset values
// ==========================================================================
`define SERIAL_IN_PIN_CONTROL_RESET      8'h02
`define SPI_OUT_PIN_CONTROL_RESET        8'h02
`define SPI_CLOCK_PIN_CONTROL_RESET      8'h02
`define GENERAL_INPUTS_PIN_CONTROL_RESET 8'h00

// ==========================================================================
// Field positions
// ==========================================================================
`define PIN_VALUE_BIT       0
`define TWO_BIT_SEL_LSB     1
`define TWO_BIT_SEL_MSB     2
`define OUT_SEL_LSB         1
`define OUT_SEL_MSB         4
`define FIRST_INPUT_SEL_LSB 5
`define FIRST_INPUT_SEL_MSB 6
`define FIRST_INPUT_VALUE   4
`define SECOND_INPUT_VALUE  0

// Bits of each register that software may store; pin-value bits are absent.
`define SERIAL_IN_WRITE_MASK      8'hFE
`define SPI_OUT_WRITE_MASK        8'hFF
`define SPI_CLOCK_WRITE_MASK      8'hFE
`define GENERAL_INPUTS_WRITE_MASK 8'hEE

`endif

// file: src/pin_select_pkg.sv
package pin_select_pkg;

  // Decoded two-bit input-pin selection; declaration order matches the codes.
  typedef enum logic [1:0] {
    IN_OFF,
    IN_PRIMARY,
    IN_GENERAL,
    IN_ALT
  } in_sel_e;

  // Decoded output-pin selection; declaration order matches the codes.
  typedef enum logic [3:0] {
    OUT_OFF,
    OUT_SPI,
    OUT_GPO,
    OUT_CLK,
    OUT_IRQ_ONE,
    OUT_IRQ_TWO,
    OUT_ADC_WCLK,
    OUT_MOD_CLK,
    OUT_SEC_DATA,
    OUT_SEC_BCLK,
    OUT_SEC_WCLK
  } out_sel_e;

  // Internal signals that may be routed onto the SPI data-output pin.
  typedef struct packed {
    logic spi_read_data;
    logic clock_output_signal;
    logic first_interrupt_output;
    logic second_interrupt_output;
    logic adc_word_clock;
    logic digital_mic_modulator_clock;
    logic secondary_serial_data;
    logic secondary_bit_clock;
    logic secondary_word_clock;
  } out_sources_s;

endpackage

// file: src/spi_out_route.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Source selection for the SPI data-output pin
// ==========================================================================
module spi_out_route
  import pin_select_pkg::*;
(
  input  wire logic [3:0]   sel,           // Raw four-bit selection field.
  input  wire logic         port_is_spi,   // High when the control port is SPI.
  input  wire logic         gpo_value,     // General-purpose output level.
  input  wire out_sources_s sources,       // Candidate signals for the pin.
  output logic              drive,         // Level to put on the pin.
  output logic              enable         // High while the pin is driven.
);

  // Pure decode; the caller registers the result so the pin never glitches
  // straight from a register write.
  always_comb begin
    drive  = 1'b0;
    enable = 1'b1;
    case (out_sel_e'(sel))
      OUT_OFF: begin
        enable = 1'b0;
      end
      OUT_SPI: begin
        drive  = sources.spi_read_data;
        enable = port_is_spi;
      end
      OUT_GPO:      drive = gpo_value;
      OUT_CLK:      drive = sources.clock_output_signal;
      OUT_IRQ_ONE:  drive = sources.first_interrupt_output;
      OUT_IRQ_TWO:  drive = sources.second_interrupt_output;
      OUT_ADC_WCLK: drive = sources.adc_word_clock;
      OUT_MOD_CLK:  drive = sources.digital_mic_modulator_clock;
      OUT_SEC_DATA: drive = sources.secondary_serial_data;
      OUT_SEC_BCLK: drive = sources.secondary_bit_clock;
      OUT_SEC_WCLK: drive = sources.secondary_word_clock;
      default: begin
        // Codes above the documented set leave the buffer powered down.
        enable = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// file: src/serial_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_select_map.svh"

module serial_pin_function_select
  import pin_select_pkg::*;
(
  input  wire logic         clk,                     // 40 MHz register clock.
  input  wire logic         arst_n,                  // Asynchronous reset.
  // Register access port.
  input  wire logic [7:0]   reg_addr,                // Register number.
  input  wire logic         reg_wr,                  // Write strobe.
  input  wire logic [7:0]   reg_wdata,               // Write data.
  input  wire logic         reg_rd,                  // Read strobe.
  output logic [7:0]        reg_rdata,               // Read data, next cycle.
  // Pin levels, already synchronous to clk.
  input  wire logic         serial_data_in_pin,      // Serial-data input pin.
  input  wire logic         spi_clock_pin,           // SPI clock pin.
  input  wire logic         first_general_input,     // First input pin.
  input  wire logic         second_general_input,    // Second input pin.
  // Sources for the SPI data-output pin.
  input  wire logic         control_port_is_spi,     // Low when control is I2C.
  input  wire out_sources_s out_sources,             // Routable signals.
  // SPI data-output pin.
  output logic              spi_out_pin_o,           // Pin level.
  output logic              spi_out_pin_oe,          // High while driven.
  // Routed input functions.
  output logic              serial_in_buffer_on,     // Input buffer powered.
  output logic              serial_in_route,         // To audio, mic, clocks.
  output logic              spi_clock_route,         // To the control port.
  output logic              spi_clock_alt_route,     // To secondary inputs.
  output logic              first_input_alt_route,   // To secondary inputs.
  output logic              second_input_alt_route,  // To secondary clocks.
  output logic              headphone_speaker_select,// Speaker select level.
  output logic [3:0]        general_purpose_input    // Pins in input mode.
);

  // ========================================================================
  // Helper functions
  // ========================================================================

  // Turns a raw two-bit field into its selection.
  function automatic in_sel_e to_in_sel(input logic [1:0] field);
    return in_sel_e'(field);
  endfunction

  // An input buffer is powered for every selection except off.
  // Reserved codes also leave it powered down, where that applies.
  function automatic logic buffer_on(input in_sel_e sel, input logic alt_ok);
    logic on;
    on = 1'b0;
    case (sel)
      IN_OFF:     on = 1'b0;
      IN_PRIMARY: on = 1'b1;
      IN_GENERAL: on = 1'b1;
      IN_ALT:     on = alt_ok;
      default:    on = 1'b0;
    endcase
    return on;
  endfunction

  // ========================================================================
  // Control registers
  // ========================================================================

  logic [7:0] serial_in_ctrl;       // Stored bits of the serial-in register.
  logic [7:0] spi_out_ctrl;         // Stored bits of the SPI-out register.
  logic [7:0] spi_clock_ctrl;       // Stored bits of the SPI-clock register.
  logic [7:0] general_inputs_ctrl;  // Stored bits of the input register.

  // Write decode. Pin-value bits are masked off so a write can never make
  // them stick; reserved read/write bits are kept as written.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_in_ctrl      <= `SERIAL_IN_PIN_CONTROL_RESET;
      spi_out_ctrl        <= `SPI_OUT_PIN_CONTROL_RESET;
      spi_clock_ctrl      <= `SPI_CLOCK_PIN_CONTROL_RESET;
      general_inputs_ctrl <= `GENERAL_INPUTS_PIN_CONTROL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `SERIAL_IN_PIN_CONTROL_ADDR: begin
          serial_in_ctrl <= reg_wdata & `SERIAL_IN_WRITE_MASK;
        end
        `SPI_OUT_PIN_CONTROL_ADDR: begin
          spi_out_ctrl <= reg_wdata & `SPI_OUT_WRITE_MASK;
        end
        `SPI_CLOCK_PIN_CONTROL_ADDR: begin
          spi_clock_ctrl <= reg_wdata & `SPI_CLOCK_WRITE_MASK;
        end
        `GENERAL_INPUTS_PIN_CONTROL_ADDR: begin
          // Reserved bits 7 and 3 are stored as written; the host is
          // expected to keep them zero.
          general_inputs_ctrl <= reg_wdata & `GENERAL_INPUTS_WRITE_MASK;
        end
        default: begin
          // Other registers live elsewhere; writes here are ignored.
        end
      endcase
    end
  end

  // ========================================================================
  // Field decode
  // ========================================================================

  in_sel_e serial_in_sel;       // Serial-in pin selection.
  in_sel_e spi_clock_sel;       // SPI-clock pin selection.
  in_sel_e first_input_sel;     // First input selection.
  in_sel_e second_input_sel;    // Second input selection.
  logic [3:0] buffer_power;     // Per-pin input-buffer power.

  assign serial_in_sel    = to_in_sel(
    serial_in_ctrl[`TWO_BIT_SEL_MSB:`TWO_BIT_SEL_LSB]);
  assign spi_clock_sel    = to_in_sel(
    spi_clock_ctrl[`TWO_BIT_SEL_MSB:`TWO_BIT_SEL_LSB]);
  assign first_input_sel  = to_in_sel(
    general_inputs_ctrl[`FIRST_INPUT_SEL_MSB:`FIRST_INPUT_SEL_LSB]);
  assign second_input_sel = to_in_sel(
    general_inputs_ctrl[`TWO_BIT_SEL_MSB:`TWO_BIT_SEL_LSB]);

  // Code 11 is reserved for the serial-in pin and the first input, so the
  // buffer stays off there; for the other two pins it is a real function.
  assign buffer_power[0] = buffer_on(serial_in_sel, 1'b0);
  assign buffer_power[1] = buffer_on(spi_clock_sel, 1'b1);
  assign buffer_power[2] = buffer_on(first_input_sel, 1'b0);
  assign buffer_power[3] = buffer_on(second_input_sel, 1'b1);

  // ========================================================================
  // Input buffers
  // ========================================================================

  logic [3:0] pin_level;        // Buffer outputs; zero while powered down.

  // A powered-down buffer reads as zero; this also keeps a floating pin
  // from toggling anything downstream.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_level <= 4'h0;
    end else begin
      pin_level <= buffer_power & {second_general_input, first_general_input,
                                   spi_clock_pin, serial_data_in_pin};
    end
  end

  // ========================================================================
  // Routed input functions
  // ========================================================================

  // Each route is registered from the raw pin so that outputs come from
  // flip-flops; they lag the pin by one clock.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_in_route          <= 1'b0;
      serial_in_buffer_on      <= 1'b0;
      spi_clock_route          <= 1'b0;
      spi_clock_alt_route      <= 1'b0;
      first_input_alt_route    <= 1'b0;
      second_input_alt_route   <= 1'b0;
      headphone_speaker_select <= 1'b0;
    end else begin
      serial_in_buffer_on <= buffer_power[0];
      serial_in_route     <= (serial_in_sel == IN_PRIMARY)
                             & serial_data_in_pin;
      spi_clock_route     <= (spi_clock_sel == IN_PRIMARY)
                             & spi_clock_pin;
      spi_clock_alt_route <= (spi_clock_sel == IN_ALT)
                             & spi_clock_pin;
      first_input_alt_route  <= (first_input_sel == IN_PRIMARY)
                                & first_general_input;
      second_input_alt_route <= (second_input_sel == IN_PRIMARY)
                                & second_general_input;
      headphone_speaker_select <= (second_input_sel == IN_ALT)
                                  & second_general_input;
    end
  end

  // Levels offered as general-purpose inputs, one bit per pin.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      general_purpose_input <= 4'h0;
    end else begin
      general_purpose_input <= {
        (second_input_sel == IN_GENERAL) & second_general_input,
        (first_input_sel == IN_GENERAL) & first_general_input,
        (spi_clock_sel == IN_GENERAL) & spi_clock_pin,
        (serial_in_sel == IN_GENERAL) & serial_data_in_pin};
    end
  end

  // ========================================================================
  // SPI data-output pin
  // ========================================================================

  logic next_spi_out;           // Selected level.
  logic next_spi_out_oe;        // Selected enable.

  spi_out_route u_spi_out_route (
    .sel         (spi_out_ctrl[`OUT_SEL_MSB:`OUT_SEL_LSB]),
    .port_is_spi (control_port_is_spi),
    .gpo_value   (spi_out_ctrl[`PIN_VALUE_BIT]),
    .sources     (out_sources),
    .drive       (next_spi_out),
    .enable      (next_spi_out_oe)
  );

  // Registered so the pin changes only on a clock edge; the price is one
  // cycle of delay on routed clocks, which matters little at audio rates.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_out_pin_o  <= 1'b0;
      spi_out_pin_oe <= 1'b0;
    end else begin
      spi_out_pin_o  <= next_spi_out & next_spi_out_oe;
      spi_out_pin_oe <= next_spi_out_oe;
    end
  end

  // ========================================================================
  // Read-back
  // ========================================================================

  // Read data is presented on the cycle after the strobe; unmapped
  // addresses return zero. Pin-value bits come from the live buffers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SERIAL_IN_PIN_CONTROL_ADDR: begin
          reg_rdata <= serial_in_ctrl | {7'h00, pin_level[0]};
        end
        `SPI_OUT_PIN_CONTROL_ADDR: begin
          reg_rdata <= spi_out_ctrl;
        end
        `SPI_CLOCK_PIN_CONTROL_ADDR: begin
          reg_rdata <= spi_clock_ctrl | {7'h00, pin_level[1]};
        end
        `GENERAL_INPUTS_PIN_CONTROL_ADDR: begin
          reg_rdata <= general_inputs_ctrl
                       | {3'h0, pin_level[2], 3'h0, pin_level[3]};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_serial_in_route: assert property (
    (serial_in_sel != IN_PRIMARY) |=> !serial_in_route)
    else $error("Serial-in route active outside primary mode.");

  chk_serial_in_read: assert property (
    (reg_rd && reg_addr == `SERIAL_IN_PIN_CONTROL_ADDR)
    |=> reg_rdata[0] == $past(pin_level[0]))
    else $error("Serial-in read bit differs from buffer level.");

  chk_out_off: assert property (
    (spi_out_ctrl[4:1] == 4'h0) |=> !spi_out_pin_oe && !spi_out_pin_o)
    else $error("SPI output pin driven while off.");

  chk_out_spi_mode: assert property (
    (spi_out_ctrl[4:1] == 4'h1)
    |=> spi_out_pin_oe == $past(control_port_is_spi)
        && (!spi_out_pin_oe || spi_out_pin_o == $past(out_sources.spi_read_data)))
    else $error("SPI read data routing wrong.");

  chk_out_gpo_level: assert property (
    (spi_out_ctrl[4:1] == 4'h2)
    |=> spi_out_pin_oe && spi_out_pin_o == $past(spi_out_ctrl[0]))
    else $error("General output level wrong.");

  chk_out_interrupt: assert property (
    (spi_out_ctrl[4:1] == 4'h5)
    |=> spi_out_pin_o == $past(out_sources.second_interrupt_output))
    else $error("Second interrupt not routed.");

  chk_out_mod_clock: assert property (
    (spi_out_ctrl[4:1] == 4'h7)
    |=> spi_out_pin_o == $past(out_sources.digital_mic_modulator_clock))
    else $error("Modulator clock not routed.");

  chk_out_sec_wclk: assert property (
    (spi_out_ctrl[4:1] == 4'hA)
    |=> spi_out_pin_o == $past(out_sources.secondary_word_clock))
    else $error("Secondary word clock not routed.");

  chk_clock_alt_route: assert property (
    (spi_clock_sel == IN_ALT && spi_clock_pin) |=> spi_clock_alt_route && !spi_clock_route)
    else $error("Clock pin not routed to secondary inputs.");

  chk_clock_read: assert property (
    (spi_clock_sel == IN_OFF) ##1 (spi_clock_sel == IN_OFF && reg_rd
      && reg_addr == `SPI_CLOCK_PIN_CONTROL_ADDR) |=> !reg_rdata[0])
    else $error("Powered-down clock buffer reads high.");

  chk_hp_select: assert property (
    (second_input_sel != IN_ALT) |=> !headphone_speaker_select)
    else $error("Speaker select active outside its mode.");

  chk_value_bits_kept: assert property (
    (reg_wr && reg_addr == `GENERAL_INPUTS_PIN_CONTROL_ADDR)
    |=> general_inputs_ctrl[4] == 1'b0 && general_inputs_ctrl[0] == 1'b0)
    else $error("Pin-value bit stored from a write.");

  cov_gpo_mode: cover property (
    (spi_out_ctrl[4:1] == 4'h2) ##1 spi_out_pin_o);
  cov_i2c_off: cover property (
    (spi_out_ctrl[4:1] == 4'h1) && !control_port_is_spi);
  cov_hp_select: cover property (headphone_speaker_select);
  // The read-data route is only worth seeing with the SPI port selected.
  cov_spi_read_out: cover property (
    (spi_out_ctrl[4:1] == 4'h1) && control_port_is_spi);
  cov_pin_read: cover property (
    reg_rd && reg_addr == `GENERAL_INPUTS_PIN_CONTROL_ADDR ##1 reg_rdata[4]);

endmodule

`default_nettype wire

// file: verif/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// External pin drivers
// ==========================================================
// Audio devices and the clock source on the far side. The
// bench moves the levels only at rising edges, so the block
// always samples a settled value.
module pin_partner
  import pin_select_pkg::*;
(
  input  wire logic [12:0]  levels,       // Requested levels.
  output logic              sin,          // Serial-data pin.
  output logic              sck,          // SPI clock pin.
  output logic              gi1,          // First input pin.
  output logic              gi2,          // Second input pin.
  output out_sources_s      src           // Routable sources.
);
  // The pins carry no keeper, so they simply follow the drivers.
  assign {sin, sck, gi1, gi2} = levels[12:9];
  assign src = levels[8:0];
endmodule

`default_nettype wire

// file: verif/tb_serial_pin_function_select.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench for the pin-function selector
// ==========================================================
module tb_serial_pin_function_select
  import pin_select_pkg::*;
();
  // A note: read data when rd is set, else pin and route outputs.
  typedef struct {logic rd; logic [12:0] exp;} note_s;
  logic         clk = 1'b0;        // 40 MHz register clock.
  logic         arst_n = 1'b0;     // Held low at start.
  logic [7:0]   reg_addr = 8'h00;  // Register number.
  logic [7:0]   reg_wdata = 8'h00; // Write data.
  logic         reg_wr = 1'b0;     // Write strobe.
  logic         reg_rd = 1'b0;     // Read strobe.
  logic         is_spi = 1'b0;     // Control port kind.
  logic         look = 1'b0;       // Output probe request.
  logic         rd_taken = 1'b0;   // Read answered this cycle.
  logic         look_taken = 1'b0; // Probe answered this cycle.
  logic [12:0]  levels = 13'h0000; // Far-side levels.
  logic [12:0]  lv;                // Levels of this step.
  logic [7:0]   reg_rdata;         // Read data.
  logic         sin, sck, gi1, gi2, o, oe, g, ib, nz;
  logic [1:0]   k;                 // Input selection code.
  out_sources_s src;               // Routable sources.
  logic [10:0]  routes;            // Routed input outputs.
  logic [7:0]   rst_v [5] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
  note_s        notes [$];         // Pending expectations.
  note_s        n;                 // Note under test.
  int           errors = 0;        // Mismatches.
  int           compares = 0;      // Comparisons made.

  // Half period of 12.5 ns gives 40 MHz.
  always #12.5 clk = ~clk;

  pin_partner far (.levels(levels), .sin(sin), .sck(sck), .gi1(gi1), .gi2(gi2), .src(src));

  serial_pin_function_select uut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_data_in_pin(sin), .spi_clock_pin(sck), .first_general_input(gi1),
    .second_general_input(gi2), .control_port_is_spi(is_spi), .out_sources(src),
    .spi_out_pin_o(o), .spi_out_pin_oe(oe), .serial_in_buffer_on(routes[10]),
    .serial_in_route(routes[9]), .spi_clock_route(routes[8]),
    .spi_clock_alt_route(routes[7]), .first_input_alt_route(routes[6]),
    .second_input_alt_route(routes[5]), .headphone_speaker_select(routes[4]),
    .general_purpose_input(routes[3:0]));

  // ==========================================================
  // Expected values
  // ==========================================================
  // Pin {oe, level} for an output selection code.
  function automatic logic [1:0] pin_exp(input logic [3:0] c, input logic gp,
                                         input logic sp, input logic [8:0] s);
    case (c)
      4'h0: pin_exp = 2'b00;
      4'h1: pin_exp = sp ? {1'b1, s[8]} : 2'b00;
      4'h2: pin_exp = {1'b1, gp};
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: begin
        pin_exp = {1'b1, s[4'hA - c]};
      end
      default: pin_exp = 2'b00;
    endcase
  endfunction

  // Routed outputs when all four input fields hold code kk.
  function automatic logic [10:0] route_exp(input logic [1:0] kk, input logic [3:0] p);
    logic a, b, c;
    a = kk == 2'b01;
    b = kk == 2'b10;
    c = kk == 2'b11;
    route_exp = {a | b, p[3] & a, p[2] & a, p[2] & c, p[1] & a, p[0] & a, p[0] & c,
                 {p[0], p[1], p[2], p[3]} & {4{b}}};
  endfunction

  // ==========================================================
  // Register and probe tasks
  // ==========================================================
  // Strobes stay up over exactly one sampling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{1'b1, {5'b00000, e}});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic probe(input logic [12:0] e);
    @(posedge clk);
    look <= 1'b1;
    notes.push_back('{1'b0, e});
    @(posedge clk);
    look <= 1'b0;
  endtask

  // ==========================================================
  // Monitor
  // ==========================================================
  // Answers are checked half a cycle after the edge that made them.
  always @(posedge clk) begin
    rd_taken <= reg_rd;
    look_taken <= look;
  end

  always @(negedge clk) begin
    if (rd_taken || look_taken) begin
      n = notes.pop_front();
      compares++;
      if ((n.rd ? {5'b00000, reg_rdata} : {oe, o, routes}) !== n.exp) begin
        errors++;
        $display("ERROR %s expected %h seen %h", n.rd ? "rdata" : "pins", n.exp,
                 n.rd ? {5'b00000, reg_rdata} : {oe, o, routes});
      end
    end
  end

  // ==========================================================
  // Verdict
  // ==========================================================
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    void'($urandom(32'hA27658D2));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    probe(13'h0400);
    wr(8'h3A, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      rd(8'h36 + 8'(i), rst_v[i]);
    end
    // Input fields from the reserved code down to off; bits 7 and 3 of
    // the shared register stay zero, pin-value bits are written as one.
    for (int i = 0; i < 4; i++) begin
      k = 2'(3 - i);
      ib = (k == 2'b01) || (k == 2'b10);
      nz = k != 2'b00;
      wr(8'h36, {5'b00000, k, 1'b1});
      wr(8'h38, {5'b00000, k, 1'b1});
      wr(8'h39, {1'b0, k, 1'b1, 1'b0, k, 1'b1});
      lv = 13'($urandom);
      levels <= lv;
      probe({2'b00, route_exp(k, lv[12:9])});
      rd(8'h36, {5'b00000, k, lv[12] & ib});
      rd(8'h38, {5'b00000, k, lv[11] & nz});
      rd(8'h39, {1'b0, k, lv[10] & ib, 1'b0, k, lv[9] & nz});
    end
    // Every output code, first under I2C and then under SPI.
    for (int i = 0; i < 32; i++) begin
      g = 1'($urandom);
      wr(8'h37, {3'b000, 4'(i), g});
      is_spi <= i[4];
      lv = 13'($urandom);
      levels <= lv;
      probe({pin_exp(4'(i), g, i[4], lv[8:0]), 11'h000});
      rd(8'h37, {3'b000, 4'(i), g});
    end
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule

`default_nettype wire
